// ===== core_storage_sequence_control.sv
// Behaviour
// - Two identical sequence controls, each emitting one fixed signal series per initiate.
// - Each reference steers its initiate to either the odd or the even control.
// - Timing pulses fill the 6.4 us right after the initiate.
// - Eight-stage recirculating loop gives eight pulses spaced 0.2 us.
// - First half copies rank one to two; second half writes rank two plus one back.
// - Four loop cycles step the counter, giving thirty-two numbered steps.
// - Rank one decodes with first-half stages, rank two with second-half stages.
// - Diverter drive from pulse 0 until pulse 24.
// - Read drive from pulse 1 until pulse 10.
// - Write drive from pulse 15 until pulse 24.
// - Inhibit drive from pulse 13 until pulse 24.
// - Sense drive from pulse 4 until pulse 12, true and complement.
// - Partial-write enables set their own flags during the read half.
// - Lower flag gates lower and non-address; upper gates non-address and upper.
// - No enables: three read strobes during sense window.
// - Both enables: three write strobes during sense window.
// - Dummy flag set at pulse 11, cleared at derived pulse 42.
// - Pulse 42 is pulse 32 passed through a ten-stage delay chain.
// - Dummy-off outputs asserted while dummy flag is set.
// - Clear strobe at pulses 7 and 25, two chassis copies.
// - Set strobe at pulse 8, two chassis copies.
// - First resume at pulse 4 of whichever control runs, shared generator.
// - Second resume at pulse 6 from either control.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module core_storage_sequence_control (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [core_seq_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              initiate_even,
  input  wire logic                              initiate_odd,
  input  wire logic                              enable_pw_lower,
  input  wire logic                              enable_pw_upper,
  output core_seq_pkg::drive_s                   drive_even,
  output core_seq_pkg::drive_s                   drive_odd,
  output logic                                   resume_first,
  output logic                                   resume_second
);

  // ****************************************************************
  // One sequence control step
  // ****************************************************************
  // Shared by both controls so they stay identical by construction.
  function automatic core_seq_pkg::seq_s seq_step(
    input core_seq_pkg::seq_s s,
    input logic               init,
    input logic               pwl,
    input logic               pwu
  );
    core_seq_pkg::seq_s n;
    logic               active;
    logic               tick;
    logic               fire;
    logic               half;
    logic [5:0]         num;
    logic [5:0]         cur;
    logic [2:0]         idx;
    logic [7:0]         ring_n;
    n      = s;
    fire   = 1'b0;
    num    = core_seq_pkg::TP_START;
    idx    = 3'h0;
    half   = 1'b0;
    ring_n = s.ring;
    active = s.running || (|s.chain);
    tick   = active && (s.cnt == core_seq_pkg::CNT_LAST);
    n.tp_fire        = 1'b0;
    n.drv.clr_z_c14  = 1'b0;
    n.drv.clr_z_c58  = 1'b0;
    n.drv.set_z_c14  = 1'b0;
    n.drv.set_z_c58  = 1'b0;
    n.cnt = !active ? core_seq_pkg::CNT_ZERO :
            (tick ? core_seq_pkg::CNT_ZERO : s.cnt + core_seq_pkg::CNT_ONE);
    // Delay chain is clocked by the step tick, not by the loop, so it keeps running after pulse 32
    if (tick) begin
      n.chain = {s.chain[core_seq_pkg::CHAIN_LEN-2:0], 1'b0};
      if (s.chain[core_seq_pkg::CHAIN_LEN-1]) begin
        n.drv.dummy_off = 1'b0;
      end
    end
    if (init && !s.running) begin
      n.running = 1'b1;
      n.ring    = '0;
      n.rank1   = core_seq_pkg::RANK1_INIT;
      n.rank2   = core_seq_pkg::RANK2_INIT;
      n.cnt     = core_seq_pkg::CNT_ZERO;
      n.pw_lo   = 1'b0;
      n.pw_hi   = 1'b0;
      fire      = 1'b1;
      num       = core_seq_pkg::TP_START;
    end else if (s.running && tick) begin
      ring_n = (s.ring == '0) ? core_seq_pkg::RING_FIRST : {s.ring[6:0], s.ring[7]};
      for (int i = 0; i < core_seq_pkg::LOOP_LEN; i++) begin
        if (ring_n[i]) begin
          idx = 3'(i);
        end
      end
      n.ring = ring_n;
      half   = (idx < 3'(core_seq_pkg::HALF_LEN));
      num    = half ? ({1'b0, s.rank1, 3'h0} + {3'h0, idx} + core_seq_pkg::TP_ONE)
                    : ({1'b0, s.rank2, 3'h0} + {3'h0, idx} + core_seq_pkg::TP_ONE);
      if (idx == core_seq_pkg::STG_COPY) begin
        n.rank2 = s.rank1;
      end
      if (idx == core_seq_pkg::STG_ADV) begin
        n.rank1 = s.rank2 + core_seq_pkg::RANK_INC;
      end
      fire = 1'b1;
      if (num == core_seq_pkg::TP_LAST) begin
        n.running  = 1'b0;
        n.chain[0] = 1'b1;
      end
    end
    if (fire) begin
      n.tp_fire = 1'b1;
      n.tp_num  = num;
      if (num == core_seq_pkg::TP_DIV_ON) begin
        n.drv.diverter = 1'b1;
      end
      if (num == core_seq_pkg::TP_DIV_OFF) begin
        n.drv.diverter = 1'b0;
      end
      if (num == core_seq_pkg::TP_RD_ON) begin
        n.drv.read = 1'b1;
      end
      if (num == core_seq_pkg::TP_RD_OFF) begin
        n.drv.read = 1'b0;
      end
      if (num == core_seq_pkg::TP_WR_ON) begin
        n.drv.write = 1'b1;
      end
      if (num == core_seq_pkg::TP_WR_OFF) begin
        n.drv.write = 1'b0;
      end
      if (num == core_seq_pkg::TP_INH_ON) begin
        n.drv.inhibit = 1'b1;
      end
      if (num == core_seq_pkg::TP_INH_OFF) begin
        n.drv.inhibit = 1'b0;
      end
      if (num == core_seq_pkg::TP_SENSE_ON) begin
        n.drv.sense = 1'b1;
      end
      if (num == core_seq_pkg::TP_SENSE_OFF) begin
        n.drv.sense = 1'b0;
      end
      if (num == core_seq_pkg::TP_DUM_ON) begin
        n.drv.dummy_off = 1'b1;
      end
      n.drv.clr_z_c14 = (num == core_seq_pkg::TP_CLRZ_A) || (num == core_seq_pkg::TP_CLRZ_B);
      n.drv.clr_z_c58 = (num == core_seq_pkg::TP_CLRZ_A) || (num == core_seq_pkg::TP_CLRZ_B);
      n.drv.set_z_c14 = (num == core_seq_pkg::TP_SETZ);
      n.drv.set_z_c58 = (num == core_seq_pkg::TP_SETZ);
    end
    // Flags only ever set inside the read half; a late enable must not change an open write
    cur = fire ? num : s.tp_num;
    if (n.running && (cur < core_seq_pkg::TP_READ_HALF)) begin
      n.pw_lo = n.pw_lo | pwl;
      n.pw_hi = n.pw_hi | pwu;
    end
    n.drv.sense_n = !n.drv.sense;
    n.drv.rd_lo   = n.drv.sense && !n.pw_lo;
    n.drv.rd_na   = n.drv.sense && !n.pw_lo && !n.pw_hi;
    n.drv.rd_hi   = n.drv.sense && !n.pw_hi;
    n.drv.wr_lo   = n.drv.sense && n.pw_lo;
    n.drv.wr_na   = n.drv.sense && n.pw_lo && n.pw_hi;
    n.drv.wr_hi   = n.drv.sense && n.pw_hi;
    return n;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  core_seq_pkg::state_s q;
  core_seq_pkg::state_s d;
  logic                 access;
  logic                 commit;
  logic                 known;
  logic [1:0]           start_sw;
  logic [31:0]          status;

  always_comb begin
    d        = q;
    start_sw = 2'h0;
    status   = 32'h0000_0000;
    access   = psel && penable;
    commit   = access && q.pready;
    known    = (paddr == core_seq_pkg::ADDR_CTRL) || (paddr == core_seq_pkg::ADDR_STATUS);
    status[core_seq_pkg::ST_BUSY_EV]     = q.ev.running || (|q.ev.chain);
    status[core_seq_pkg::ST_BUSY_OD]     = q.od.running || (|q.od.chain);
    status[core_seq_pkg::ST_DUM_EV]      = q.ev.drv.dummy_off;
    status[core_seq_pkg::ST_DUM_OD]      = q.od.drv.dummy_off;
    status[core_seq_pkg::ST_TP_EV +: 6]  = q.ev.tp_num;
    status[core_seq_pkg::ST_TP_OD +: 6]  = q.od.tp_num;
    status[core_seq_pkg::ST_PW_EV +: 2]  = {q.ev.pw_hi, q.ev.pw_lo};
    status[core_seq_pkg::ST_PW_OD +: 2]  = {q.od.pw_hi, q.od.pw_lo};
    // One wait state keeps pready and prdata on flip-flops
    d.pready  = access && !q.pready;
    d.pslverr = access && !q.pready && !known;
    d.prdata  = 32'h0000_0000;
    if (access && !q.pready && !pwrite) begin
      if (paddr == core_seq_pkg::ADDR_CTRL) begin
        d.prdata[core_seq_pkg::CTRL_PW_LO] = q.ctrl_pw[0];
        d.prdata[core_seq_pkg::CTRL_PW_HI] = q.ctrl_pw[1];
      end else if (paddr == core_seq_pkg::ADDR_STATUS) begin
        d.prdata = status;
      end
    end
    if (commit && pwrite && (paddr == core_seq_pkg::ADDR_CTRL)) begin
      d.ctrl_pw  = {pwdata[core_seq_pkg::CTRL_PW_HI], pwdata[core_seq_pkg::CTRL_PW_LO]};
      start_sw   = {pwdata[core_seq_pkg::CTRL_START_ODD], pwdata[core_seq_pkg::CTRL_START_EVEN]};
    end
    d.ev = seq_step(q.ev, initiate_even || start_sw[0],
                    enable_pw_lower || q.ctrl_pw[0], enable_pw_upper || q.ctrl_pw[1]);
    d.od = seq_step(q.od, initiate_odd || start_sw[1],
                    enable_pw_lower || q.ctrl_pw[0], enable_pw_upper || q.ctrl_pw[1]);
    d.resume1 = (d.ev.tp_fire && (d.ev.tp_num == core_seq_pkg::TP_RESUME1))
             || (d.od.tp_fire && (d.od.tp_num == core_seq_pkg::TP_RESUME1));
    d.resume2 = (d.ev.tp_fire && (d.ev.tp_num == core_seq_pkg::TP_RESUME2))
             || (d.od.tp_fire && (d.od.tp_num == core_seq_pkg::TP_RESUME2));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                 <= '0;
      q.ev.drv.sense_n  <= 1'b1;
      q.od.drv.sense_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign drive_even    = q.ev.drv;
  assign drive_odd     = q.od.drv;
  assign resume_first  = q.resume1;
  assign resume_second = q.resume2;

  // ****************************************************************
  // Checks on the even control, plus diverter, resume, dummy and sense checks on the odd control
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    $rose(drive_even.diverter);
  endsequence

  property p_start_num;
    s_start |-> q.ev.tp_fire && (q.ev.tp_num == core_seq_pkg::TP_START);
  endproperty
  a_start_num: assert property (p_start_num) else $error("Diverter rose off pulse 0");

  property p_div_len;
    s_start |-> ##47 drive_even.diverter ##1 !drive_even.diverter;
  endproperty
  a_div_len: assert property (p_div_len) else $error("Diverter window length wrong");

  property p_read_win;
    s_start |-> ##2 $rose(drive_even.read) ##17 drive_even.read ##1 !drive_even.read;
  endproperty
  a_read_win: assert property (p_read_win) else $error("Read window wrong");

  property p_write_win;
    s_start |-> ##30 $rose(drive_even.write) ##17 drive_even.write ##1 !drive_even.write;
  endproperty
  a_write_win: assert property (p_write_win) else $error("Write window wrong");

  property p_inh_win;
    s_start |-> ##26 $rose(drive_even.inhibit) ##21 drive_even.inhibit ##1 !drive_even.inhibit;
  endproperty
  a_inh_win: assert property (p_inh_win) else $error("Inhibit window wrong");

  property p_sense_win;
    s_start |-> ##8 $rose(drive_even.sense) ##15 drive_even.sense ##1 !drive_even.sense;
  endproperty
  a_sense_win: assert property (p_sense_win) else $error("Sense window wrong");

  property p_dummy;
    s_start |-> ##22 $rose(drive_even.dummy_off) ##61 drive_even.dummy_off ##1 !drive_even.dummy_off;
  endproperty
  a_dummy: assert property (p_dummy) else $error("Dummy window wrong");

  property p_resume;
    (s_start and !drive_odd.diverter) |-> ##8 resume_first ##4 resume_second;
  endproperty
  a_resume: assert property (p_resume) else $error("Resume timing wrong");

  property p_zstrobe;
    s_start |-> ##14 drive_even.clr_z_c14 ##2 drive_even.set_z_c58 ##34 drive_even.clr_z_c58;
  endproperty
  a_zstrobe: assert property (p_zstrobe) else $error("Z strobe timing wrong");

  property p_strobe_gate;
    drive_even.wr_na |-> drive_even.sense && !drive_even.rd_lo && !drive_even.rd_hi;
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("Read and write strobes overlap");

  property p_last;
    s_start |-> ##64 (q.ev.tp_fire && (q.ev.tp_num == core_seq_pkg::TP_LAST) && !q.ev.running);
  endproperty
  a_last: assert property (p_last) else $error("Pulse 32 not at end of cycle");

  sequence s_start_od;
    $rose(drive_odd.diverter);
  endsequence

  property p_odd_num;
    s_start_od |-> q.od.tp_fire && (q.od.tp_num == core_seq_pkg::TP_START);
  endproperty
  a_odd_num: assert property (p_odd_num) else $error("Odd diverter rose off pulse 0");

  property p_odd_div;
    s_start_od |-> ##47 drive_odd.diverter ##1 !drive_odd.diverter;
  endproperty
  a_odd_div: assert property (p_odd_div) else $error("Odd diverter window wrong");

  property p_odd_resume;
    (s_start_od and !drive_even.diverter) |-> ##8 resume_first ##4 resume_second;
  endproperty
  a_odd_resume: assert property (p_odd_resume) else $error("Odd resume timing wrong");

  property p_odd_dummy;
    s_start_od |-> ##22 $rose(drive_odd.dummy_off) ##61 drive_odd.dummy_off ##1 !drive_odd.dummy_off;
  endproperty
  a_odd_dummy: assert property (p_odd_dummy) else $error("Odd dummy window wrong");

  property p_sense_n;
    (drive_even.sense_n != drive_even.sense) && (drive_odd.sense_n != drive_odd.sense);
  endproperty
  a_sense_n: assert property (p_sense_n) else $error("Sense complement wrong");

  property p_rd_gate;
    drive_even.rd_na |-> drive_even.sense && !drive_even.wr_lo && !drive_even.wr_hi;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("Read strobe with write strobe");

  property p_clr_pair;
    drive_even.clr_z_c14 |-> drive_even.clr_z_c58 && !drive_even.set_z_c14;
  endproperty
  a_clr_pair: assert property (p_clr_pair) else $error("Clear strobe copies differ");

  property p_set_pair;
    drive_even.set_z_c14 |-> drive_even.set_z_c58 && $past(drive_even.clr_z_c14, 2);
  endproperty
  a_set_pair: assert property (p_set_pair) else $error("Set strobe out of place");

  property p_pw_late;
    q.ev.running && (q.ev.tp_num >= core_seq_pkg::TP_READ_HALF) |=> $stable({q.ev.pw_hi, q.ev.pw_lo});
  endproperty
  a_pw_late: assert property (p_pw_late) else $error("Partial-write flag moved in write half");

  property p_tail;
    $fell(q.ev.running) |-> q.ev.chain[0] && q.ev.drv.dummy_off;
  endproperty
  a_tail: assert property (p_tail) else $error("Delay chain not started at pulse 32");

  property p_step;
    q.ev.tp_fire && q.ev.running |=> !q.ev.tp_fire ##1 q.ev.tp_fire;
  endproperty
  a_step: assert property (p_step) else $error("Timing pulse spacing wrong");

endmodule

`default_nettype wire

// ===== core_seq_pkg.sv
package core_seq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS   = 100;
  localparam int STEP_NS  = 200;
  localparam int STEP_CYC = STEP_NS / CLK_NS;

  localparam logic [1:0] CNT_LAST   = 2'(STEP_CYC - 1);
  localparam logic [1:0] CNT_ZERO   = 2'h0;
  localparam logic [1:0] CNT_ONE    = 2'h1;
  localparam int         LOOP_LEN   = 8;
  localparam int         HALF_LEN   = 4;
  localparam int         CHAIN_LEN  = 10;
  localparam logic [7:0] RING_FIRST = 8'h01;
  localparam logic [2:0] STG_COPY   = 3'h1;
  localparam logic [2:0] STG_ADV    = 3'h5;
  localparam logic [1:0] RANK1_INIT = 2'h0;
  localparam logic [1:0] RANK2_INIT = 2'h3;
  localparam logic [1:0] RANK_INC   = 2'h1;

  // ****************************************************************
  // Timing pulse numbers
  // ****************************************************************
  localparam logic [5:0] TP_START     = 6'h00;
  localparam logic [5:0] TP_DIV_ON    = 6'h00;
  localparam logic [5:0] TP_RD_ON     = 6'h01;
  localparam logic [5:0] TP_SENSE_ON  = 6'h04;
  localparam logic [5:0] TP_RESUME1   = 6'h04;
  localparam logic [5:0] TP_RESUME2   = 6'h06;
  localparam logic [5:0] TP_CLRZ_A    = 6'h07;
  localparam logic [5:0] TP_SETZ      = 6'h08;
  localparam logic [5:0] TP_RD_OFF    = 6'h0A;
  localparam logic [5:0] TP_DUM_ON    = 6'h0B;
  localparam logic [5:0] TP_SENSE_OFF = 6'h0C;
  localparam logic [5:0] TP_INH_ON    = 6'h0D;
  localparam logic [5:0] TP_WR_ON     = 6'h0F;
  localparam logic [5:0] TP_READ_HALF = 6'h10;
  localparam logic [5:0] TP_DIV_OFF   = 6'h18;
  localparam logic [5:0] TP_WR_OFF    = 6'h18;
  localparam logic [5:0] TP_INH_OFF   = 6'h18;
  localparam logic [5:0] TP_CLRZ_B    = 6'h19;
  localparam logic [5:0] TP_LAST      = 6'h20;
  localparam logic [5:0] TP_ONE       = 6'h01;

  // ****************************************************************
  // APB map
  // ****************************************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_START_EVEN = 0;
  localparam int CTRL_START_ODD  = 1;
  localparam int CTRL_PW_LO      = 2;
  localparam int CTRL_PW_HI      = 3;
  localparam int ST_BUSY_EV      = 0;
  localparam int ST_BUSY_OD      = 1;
  localparam int ST_DUM_EV       = 2;
  localparam int ST_DUM_OD       = 3;
  localparam int ST_TP_EV        = 4;
  localparam int ST_TP_OD        = 10;
  localparam int ST_PW_EV        = 16;
  localparam int ST_PW_OD        = 18;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic diverter;
    logic read;
    logic write;
    logic inhibit;
    logic sense;
    logic sense_n;
    logic rd_lo;
    logic rd_na;
    logic rd_hi;
    logic wr_lo;
    logic wr_na;
    logic wr_hi;
    logic dummy_off;
    logic clr_z_c14;
    logic clr_z_c58;
    logic set_z_c14;
    logic set_z_c58;
  } drive_s;

  typedef struct packed {
    logic         running;
    logic [7:0]   ring;
    logic [1:0]   rank1;
    logic [1:0]   rank2;
    logic [1:0]   cnt;
    logic [9:0]   chain;
    logic         pw_lo;
    logic         pw_hi;
    logic         tp_fire;
    logic [5:0]   tp_num;
    drive_s       drv;
  } seq_s;

  typedef struct packed {
    seq_s        ev;
    seq_s        od;
    logic        resume1;
    logic        resume2;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [1:0]  ctrl_pw;
  } state_s;

endpackage

// ===== control_section_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Requester side: steers each reference to one control, spaced out
// ****************************************************************
module control_section_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic req,
  input  wire logic req_odd,
  input  wire logic pw_lo,
  input  wire logic pw_hi,
  output logic      initiate_even,
  output logic      initiate_odd,
  output logic      enable_pw_lower,
  output logic      enable_pw_upper
);
  logic [6:0] hold_ev_q;
  logic [6:0] hold_od_q;

  // Levels held for the whole reference so the read half sees them steady
  assign enable_pw_lower = pw_lo;
  assign enable_pw_upper = pw_hi;

  // A request waits until the chosen control has finished its 32 steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      initiate_even <= 1'b0;
      initiate_odd  <= 1'b0;
      hold_ev_q     <= 7'h00;
      hold_od_q     <= 7'h00;
    end else begin
      initiate_even <= req && !req_odd && hold_ev_q == 7'h00;
      initiate_odd  <= req && req_odd && hold_od_q == 7'h00;
      if (initiate_even) begin
        hold_ev_q <= 7'h42;
      end else if (hold_ev_q != 7'h00) begin
        hold_ev_q <= hold_ev_q - 7'h01;
      end
      if (initiate_odd) begin
        hold_od_q <= 7'h42;
      end else if (hold_od_q != 7'h00) begin
        hold_od_q <= hold_od_q - 7'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ===== core_storage_sequence_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module core_storage_sequence_control_tb;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 err, req, req_odd, pw_lo, pw_hi, resume_first, resume_second;
  logic                 initiate_even, initiate_odd, enable_pw_lower, enable_pw_upper;
  core_seq_pkg::drive_s drive_even, drive_odd;
  int                   err_total, total_checks;

  core_storage_sequence_control core_storage_sequence_control_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initiate_even(initiate_even), .initiate_odd(initiate_odd),
    .enable_pw_lower(enable_pw_lower), .enable_pw_upper(enable_pw_upper),
    .drive_even(drive_even), .drive_odd(drive_odd),
    .resume_first(resume_first), .resume_second(resume_second));

  control_section_model control_section_model_i (
    .pclk(pclk), .presetn(presetn), .req(req), .req_odd(req_odd), .pw_lo(pw_lo), .pw_hi(pw_hi),
    .initiate_even(initiate_even), .initiate_odd(initiate_odd),
    .enable_pw_lower(enable_pw_lower), .enable_pw_upper(enable_pw_upper));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cycle k after the sampling edge; pulse n lands in cycle 1+2n
  function automatic logic on(int k, int a, int b);
    return k >= 1 + 2 * a && k < 1 + 2 * b;
  endfunction

  function automatic core_seq_pkg::drive_s exp_drv(int k, logic pwl, logic pwu);
    core_seq_pkg::drive_s d;
    logic                 s;
    d           = '0;
    s           = on(k, 4, 12);
    d.diverter  = on(k, 0, 24);
    d.read      = on(k, 1, 10);
    d.write     = on(k, 15, 24);
    d.inhibit   = on(k, 13, 24);
    d.sense     = s;
    d.sense_n   = !s;
    d.rd_lo     = s && !pwl;
    d.rd_na     = s && !pwl && !pwu;
    d.rd_hi     = s && !pwu;
    d.wr_lo     = s && pwl;
    d.wr_na     = s && pwl && pwu;
    d.wr_hi     = s && pwu;
    d.dummy_off = on(k, 11, 42);
    d.clr_z_c14 = k == 15 || k == 51;
    d.clr_z_c58 = k == 15 || k == 51;
    d.set_z_c14 = k == 17;
    d.set_z_c58 = k == 17;
    return d;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic watch_seq(input logic odd, input logic pwl, input logic pwu, input int k0);
    for (int k = k0; k <= 90; k++) begin
      @(negedge pclk);
      check((odd ? drive_odd : drive_even) === exp_drv(k, pwl, pwu), "running drive");
      check((odd ? drive_even : drive_odd) === exp_drv(0, 1'b0, 1'b0), "idle drive");
      check(resume_first === (k == 9), "resume first");
      check(resume_second === (k == 13), "resume second");
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge pclk);
    check(drive_even === exp_drv(0, 1'b0, 1'b0) && drive_odd === exp_drv(0, 1'b0, 1'b0), "reset drive");
    check(resume_first === 1'b0 && resume_second === 1'b0 && pready === 1'b0, "reset pulses");
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(rd === 32'h0000_0000 && err === 1'b0, "reset status");
  endtask

  // Every enable combination on the even control, then the odd one by pins
  task automatic t_pw_modes();
    for (int m = 0; m < 5; m++) begin
      @(posedge pclk);
      pw_lo   <= m[0] && m < 4;
      pw_hi   <= m[1] && m < 4;
      req_odd <= m == 4;
      req     <= 1'b1;
      @(posedge pclk);
      req <= 1'b0;
      @(posedge pclk iff (initiate_even || initiate_odd));
      watch_seq(m == 4, m[0] && m < 4, m[1] && m < 4, 1);
    end
  endtask

  // Start by register with both software enables, then read back state
  task automatic t_apb_start();
    int n;
    apb(1'b1, 12'h000, 32'h0000_000E);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (drive_odd.diverter !== 1'b1 && n < 12);
    check(n < 12, "register start");
    watch_seq(1'b1, 1'b1, 1'b1, 2);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd === 32'h0000_000C && err === 1'b0, "control readback");
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(rd === 32'h000F_8200 && err === 1'b0, "status after cycles");
    apb(1'b1, 12'h000, 32'h0000_0000);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h008, 32'h0000_000F);
    check(err === 1'b1, "unmapped write error");
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(rd === 32'h0000_0000 && err === 1'b1, "unmapped read");
    apb(1'b0, 12'h000, 32'h0000_0000);
    check(rd === 32'h0000_0000 && err === 1'b0, "control untouched");
    apb(1'b1, 12'h000, 32'h0000_0001);
    watch_seq(1'b0, 1'b0, 1'b0, 1);
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Whole run is about 700 cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0000_0000;
    req          = 1'b0;
    req_odd      = 1'b0;
    pw_lo        = 1'b0;
    pw_hi        = 1'b0;
    err_total    = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pw_modes();
    t_apb_start();
    t_unmapped();
    tally_and_finish();
  end
endmodule

`default_nettype wire
